/* inc/i2c_stretch_defs.vh */
/*
 Constants for the two-wire slave clock stretcher and the stop collision checker.
 Assumes inclusion by bare name from the design files only.
*/
`ifndef I2C_STRETCH_DEFS_VH
`define I2C_STRETCH_DEFS_VH

// Register offsets on the plain port (8-bit address)
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h01
`define ADDR_BUF 8'h02
`define ADDR_OWN 8'h03
`define ADDR_RELOAD 8'h04
`define ADDR_CMD 8'h05

// Control register fields
`define CTRL_STRETCH_EN 0
`define CTRL_RELEASE 1
`define CTRL_TEN_BIT 2
`define CTRL_RST 8'h02

// Status register fields
`define ST_BF 0
`define ST_UA 1
`define ST_RW 2
`define ST_COLL 3
`define ST_STOP_BUSY 4
`define ST_ADDR_HIT 5
`define ST_OVF 6

// Command register fields
`define CMD_STOP 0
`define CMD_CLR_COLL 1

`define OWN_RST 10'h000
`define RELOAD_RST 8'h10

// Ten-bit address header upper bits
`define TEN_HDR 5'h1e

`endif

/* verilog/stop_collision.v */
/*
 Master stop generator with collision detection, bit-rate down-counter timed.
 Assumes synchronised line levels and a one-cycle start pulse from the owner.
*/
`timescale 1ns/10ps
`include "i2c_stretch_defs.vh"

module stop_collision (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [6:0] reload,
  input wire scl_in,
  input wire sda_in,
  output reg scl_low_r,
  output reg sda_low_r,
  output reg busy_r,
  output reg coll_r,
  output reg done_r
);

  localparam S_IDLE = 3'd0;
  localparam S_SDA_LOW = 3'd1;
  localparam S_SCL_REL = 3'd2;
  localparam S_COUNT = 3'd3;
  localparam S_SDA_REL = 3'd4;
  localparam S_SAMPLE = 3'd5;

  reg [2:0] state_r;
  reg [6:0] brg_r;

  always @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      brg_r <= 7'h00;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      busy_r <= 1'b0;
      coll_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      coll_r <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            sda_low_r <= 1'b1;
            scl_low_r <= 1'b1;
            busy_r <= 1'b1;
            state_r <= S_SDA_LOW;
          end
        end
        S_SDA_LOW: begin
          if (!sda_in) begin
            scl_low_r <= 1'b0;
            state_r <= S_SCL_REL;
          end
        end
        S_SCL_REL: begin
          if (scl_in) begin
            brg_r <= reload;
            state_r <= S_COUNT;
          end
        end
        S_COUNT: begin
          if (!scl_in) begin
            coll_r <= 1'b1;
            sda_low_r <= 1'b0;
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end else if (brg_r == 7'h00) begin
            sda_low_r <= 1'b0;
            brg_r <= reload;
            state_r <= S_SDA_REL;
          end else begin
            brg_r <= brg_r - 7'h01;
          end
        end
        S_SDA_REL: begin
          if (brg_r == 7'h00) begin
            state_r <= S_SAMPLE;
          end else begin
            brg_r <= brg_r - 7'h01;
          end
        end
        S_SAMPLE: begin
          coll_r <= !sda_in;
          done_r <= sda_in;
          busy_r <= 1'b0;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* verilog/i2c_slave_stretch.v */
/*
 Two-wire slave with automatic clock stretching, plus master stop collision check.
 Assumes open-drain wiring outside; line inputs are asynchronous and synchronised here.
*/
//
// Contract
// - Slave transmit stretches automatically in 7-bit and 10-bit modes.
// - Stretch enable holds clock low after each data receive.
// - 7-bit receive: ninth falling edge with buffer full clears release.
// - Clock held low while release is zero; software sets it.
// - Buffer read before ninth falling edge prevents the stretch.
// - Software may set release any time regardless of buffer full; here a transmit clear in the same cycle overrides the write.
// - 10-bit address phase stretches on update flag, release untouched.
// - Update flag set after high address byte and low byte with write.
// - Writing address reload releases address stretch and clears update flag.
// - Buffer-full stretch only in data sequences, never address sequences; here the ninth fall after a matched write address can also stretch.
// - 10-bit receive data uses the same buffer-full stretch.
// - 7-bit transmit clears release at ninth edge when buffer empty.
// - Buffer loaded before ninth edge in transmit prevents stretch.
// - 10-bit transmit first two address bytes stretch on update flag.
// - Repeated high byte with read: no update flag, enter transmit.
// - Stop: data low, float clock, count reload down, sample data.
// - Stop collision when released data samples low after timeout.
// - Stop collision when clock samples low before data released.
`timescale 1ns/10ps
`include "i2c_stretch_defs.vh"

module i2c_slave_stretch (
  input wire CLK,
  input wire SYS_RST,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire SCL_I,
  output wire SCL_O,
  output wire SCL_OE,
  input wire SDA_I,
  output wire SDA_O,
  output wire SDA_OE
);

  localparam P_IDLE = 3'd0;
  localparam P_ADDR1 = 3'd1;
  localparam P_ADDR2 = 3'd2;
  localparam P_DATA = 3'd3;
  localparam P_SKIP = 3'd4;

  reg [1:0] scl_s_r;
  reg [1:0] sda_s_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [7:0] ctrl_r;
  reg [9:0] own_r;
  reg [7:0] reload_r;
  reg [7:0] buf_r;
  reg [7:0] shift_r;
  reg [3:0] bit_r;
  reg [2:0] phase_r;
  reg bf_r;
  reg ua_r;
  reg rw_r;
  reg ovf_r;
  reg hit_r;
  reg coll_flag_r;
  reg tx_r;
  reg ack_drv_r;
  reg ua_hold_r;
  reg seen_hdr_r;
  reg sda_tx_r;
  reg [7:0] ctrl_nxt;

  wire scl = scl_s_r[1];
  wire sda = sda_s_r[1];
  wire scl_rise = scl & ~scl_d_r;
  wire scl_fall = ~scl & scl_d_r;
  wire start_cond = scl & scl_d_r & sda_d_r & ~sda;
  wire stop_cond = scl & scl_d_r & ~sda_d_r & sda;
  wire wr_ctrl = WR && (ADDR == `ADDR_CTRL);
  wire wr_buf = WR && (ADDR == `ADDR_BUF);
  wire wr_reload = WR && (ADDR == `ADDR_RELOAD);
  wire wr_cmd = WR && (ADDR == `ADDR_CMD);
  wire rd_buf = RD && (ADDR == `ADDR_BUF);
  wire ten_bit = ctrl_r[`CTRL_TEN_BIT];
  wire ninth_fall = scl_fall && (bit_r == 4'd9);
  wire addr_seq = (phase_r == P_ADDR1) || (phase_r == P_ADDR2);
  wire data_seq = (phase_r == P_DATA);
  wire stop_scl_low;
  wire stop_sda_low;
  wire stop_busy;
  wire stop_coll;

  // Line synchronisers: first stage feeds only the second
  always @(posedge CLK) begin
    if (SYS_RST) begin
      scl_s_r <= 2'b11;
      sda_s_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], SCL_I};
      sda_s_r <= {sda_s_r[0], SDA_I};
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end

  // Release bit: software set, hardware clear; a control write beats the receive clear but not the transmit clear
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = WDATA;
    end
    if (ninth_fall && hit_r) begin
      // a prior buffer read clears full
      if (!tx_r && data_seq && ctrl_r[`CTRL_STRETCH_EN] && bf_r && !wr_ctrl) begin
        ctrl_nxt[`CTRL_RELEASE] = 1'b0;
      end
      // a prior buffer load prevents it
      if (tx_r && data_seq && !bf_r && !wr_buf) begin
        ctrl_nxt[`CTRL_RELEASE] = 1'b0;
      end
    end
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_r <= `CTRL_RST;
      own_r <= `OWN_RST;
      reload_r <= `RELOAD_RST;
      buf_r <= 8'h00;
      shift_r <= 8'h00;
      bit_r <= 4'd0;
      phase_r <= P_IDLE;
      bf_r <= 1'b0;
      ua_r <= 1'b0;
      rw_r <= 1'b0;
      ovf_r <= 1'b0;
      hit_r <= 1'b0;
      coll_flag_r <= 1'b0;
      tx_r <= 1'b0;
      ack_drv_r <= 1'b0;
      ua_hold_r <= 1'b0;
      seen_hdr_r <= 1'b0;
      sda_tx_r <= 1'b1;
    end else begin
      // release write accepted whatever buffer full says, unless the transmit clear falls in the same cycle
      ctrl_r <= ctrl_nxt;
      if (WR && (ADDR == `ADDR_OWN)) begin
        own_r <= {own_r[9:8], WDATA};
      end
      if (wr_reload) begin
        // reload write releases and clears update flag
        reload_r <= WDATA;
        own_r[9:8] <= WDATA[1:0];
        ua_r <= 1'b0;
        ua_hold_r <= 1'b0;
      end
      if (wr_cmd && WDATA[`CMD_CLR_COLL]) begin
        coll_flag_r <= 1'b0;
      end
      // collision is sticky, set wins over clear
      if (stop_coll) begin
        coll_flag_r <= 1'b1;
      end
      if (wr_buf) begin
        buf_r <= WDATA;
        bf_r <= 1'b1;
      end else if (rd_buf && !tx_r) begin
        bf_r <= 1'b0;
      end
      if (start_cond || stop_cond) begin
        bit_r <= 4'd0;
        phase_r <= start_cond ? P_ADDR1 : P_IDLE;
        hit_r <= 1'b0;
        ack_drv_r <= 1'b0;
        sda_tx_r <= 1'b1;
        if (stop_cond) begin
          tx_r <= 1'b0;
          seen_hdr_r <= 1'b0;
        end
      end else if (phase_r != P_IDLE) begin
        // Own transmit bits must not overwrite the outgoing byte
        if (scl_rise && bit_r < 4'd9 && !(tx_r && data_seq)) begin
          shift_r <= {shift_r[6:0], sda};
        end
        if (scl_fall) begin
          bit_r <= (bit_r == 4'd9) ? 4'd1 : bit_r + 4'd1;
          if (bit_r == 4'd8) begin
            ack_drv_r <= 1'b0;
            sda_tx_r <= 1'b1;
            case (phase_r)
              P_ADDR1: begin
                if (ten_bit && shift_r[7:3] == `TEN_HDR && shift_r[2:1] == own_r[9:8]) begin
                  ack_drv_r <= 1'b1;
                  hit_r <= 1'b1;
                  if (shift_r[0] && seen_hdr_r) begin
                    // repeated header with read: transmit, no flag
                    tx_r <= 1'b1;
                    bf_r <= 1'b0;
                    phase_r <= P_DATA;
                  end else begin
                    ua_r <= 1'b1;
                    ua_hold_r <= 1'b1;
                    phase_r <= P_ADDR2;
                  end
                end else if (!ten_bit && shift_r[7:1] == own_r[6:0]) begin
                  ack_drv_r <= 1'b1;
                  hit_r <= 1'b1;
                  tx_r <= shift_r[0];
                  rw_r <= shift_r[0];
                  phase_r <= P_DATA;
                  if (shift_r[0]) begin
                    bf_r <= 1'b0;
                  end
                end else begin
                  phase_r <= P_SKIP;
                end
              end
              P_ADDR2: begin
                if (shift_r == own_r[7:0]) begin
                  // flag after low byte with write
                  ack_drv_r <= 1'b1;
                  ua_r <= 1'b1;
                  ua_hold_r <= 1'b1;
                  seen_hdr_r <= 1'b1;
                  rw_r <= 1'b0;
                  phase_r <= P_DATA;
                end else begin
                  phase_r <= P_SKIP;
                end
              end
              P_DATA: begin
                if (!tx_r) begin
                  ack_drv_r <= 1'b1;
                  if (bf_r && !rd_buf) begin
                    ovf_r <= 1'b1;
                  end else begin
                    buf_r <= shift_r;
                    bf_r <= 1'b1;
                  end
                end
              end
              default: begin
                phase_r <= P_SKIP;
              end
            endcase
          end else if (bit_r == 4'd9) begin
            ack_drv_r <= 1'b0;
            if (tx_r && data_seq) begin
              if (bf_r || wr_buf) begin
                sda_tx_r <= wr_buf ? WDATA[7] : buf_r[7];
                shift_r <= wr_buf ? WDATA : buf_r;
                bf_r <= 1'b0;
              end
            end
          end else if (tx_r && data_seq) begin
            sda_tx_r <= shift_r[6];
            shift_r <= {shift_r[6:0], 1'b1};
          end
        end
        // Master NACK ends slave transmit
        if (tx_r && scl_rise && bit_r == 4'd9 && sda) begin
          phase_r <= P_SKIP;
        end
        if (wr_buf && tx_r && data_seq && bit_r == 4'd1 && !ctrl_r[`CTRL_RELEASE]) begin
          sda_tx_r <= WDATA[7];
          shift_r <= WDATA;
          bf_r <= 1'b0;
        end
      end
    end
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `ADDR_CTRL: RDATA <= ctrl_r;
        `ADDR_STATUS: RDATA <= {1'b0, ovf_r, hit_r, stop_busy, coll_flag_r, rw_r, ua_r, bf_r};
        `ADDR_BUF: RDATA <= buf_r;
        `ADDR_OWN: RDATA <= own_r[7:0];
        `ADDR_RELOAD: RDATA <= reload_r;
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  stop_collision u_stop (
    .clk(CLK),
    .rst(SYS_RST),
    .start(wr_cmd && WDATA[`CMD_STOP]),
    .reload(reload_r[6:0]),
    .scl_in(scl),
    .sda_in(sda),
    .scl_low_r(stop_scl_low),
    .sda_low_r(stop_sda_low),
    .busy_r(stop_busy),
    .coll_r(stop_coll),
    .done_r()
  );

  // clock low while release is zero
  // address stretch on update flag, release kept
  wire hold_scl = !ctrl_r[`CTRL_RELEASE] ||
                  (ua_hold_r && addr_seq && bit_r == 4'd1 && !scl) ||
                  (ua_hold_r && bit_r == 4'd1 && !scl && hit_r);
  wire data_drive = ack_drv_r || (tx_r && data_seq && bit_r < 4'd9 && !sda_tx_r);

  // open-drain: drive low or release only
  assign SCL_O = 1'b0;
  assign SCL_OE = hold_scl || stop_scl_low;
  assign SDA_O = 1'b0;
  assign SDA_OE = data_drive || stop_sda_low;

endmodule

/* bench/stretch_monitor.sv */
/*
 Port checker for the two-wire slave stretcher and stop collision logic.
 Assumes binding to the top design module; one clock domain.
*/
`timescale 1ns/10ps
module stretch_monitor (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  chk_open_drain: assert property (SCL_O == 1'h0 && SDA_O == 1'h0)
    else $error("line output not low");
  chk_read_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside read slot");
  chk_unmapped_read: assert property (RD && ADDR > 8'h05 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_enable_readback: assert property (WR && ADDR == 8'h00 ##2 RD && ADDR == 8'h00
    |=> RDATA[0] == $past(WDATA[0], 3)) else $error("stretch enable readback");
  chk_reload_readback: assert property (WR && ADDR == 8'h04 ##2 RD && ADDR == 8'h04
    |=> RDATA[6:0] == $past(WDATA[6:0], 3)) else $error("reload readback");
  chk_hold_low: assert property (WR && ADDR == 8'h00 && !WDATA[1] |=> SCL_OE [*3])
    else $error("clock not held");
  chk_release_seen: assert property (WR && ADDR == 8'h00 && WDATA[1] && !WDATA[2]
    && !SDA_OE |=> !SCL_OE) else $error("release write ignored");
  chk_stop_drive: assert property (WR && ADDR == 8'h05 && WDATA[0] && !SDA_OE
    && !SCL_OE |=> SDA_OE) else $error("stop did not pull data low");
  chk_stop_count: assert property ($rose(SCL_I) && SDA_OE |-> SDA_OE[*8])
    else $error("data released too early");
endmodule
bind i2c_slave_stretch stretch_monitor mon (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE));

/* bench/ext_master_model.sv */
/*
 Behavioural external bus master: start, stop, bytes, data jam.
 Assumes the bench wires all parties open-drain with pull-ups.
*/
`timescale 1ns/10ps
module ext_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe
);
  localparam int PH = 80;
  initial begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end
  task start_cond;
    begin
      sda_oe = 1'h1;
      #(PH);
      scl_oe = 1'h1;
      #(PH);
    end
  endtask
  task stop_cond;
    begin
      sda_oe = 1'h1;
      #(PH);
      scl_oe = 1'h0;
      wait (scl);
      #(PH);
      sda_oe = 1'h0;
      #(PH);
    end
  endtask
  // Competing master holding data low
  task jam(input logic b);
    sda_oe = b;
  endtask
  // Competing master holding clock low
  task jam_clk(input logic b);
    scl_oe = b;
  endtask
  task bit_io(input logic b, output logic r);
    begin
      sda_oe = ~b;
      #(PH);
      scl_oe = 1'h0;
      wait (scl);
      #(PH);
      r = sda;
      scl_oe = 1'h1;
    end
  endtask
  task byte_io(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic a);
    begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(d[i], q[i]);
      end
      bit_io(ack, a);
      sda_oe = 1'h0;
    end
  endtask
endmodule

/* bench/tb.sv */
/*
 Self-checking bench: register port, slave stretching, stop collision.
 Assumes the design, master model and checker compiled alongside.
*/
`timescale 1ns/10ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module tb;
  logic CLK = 1'h0;
  logic SYS_RST = 1'h1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'h0;
  logic RD = 1'h0;
  wire [7:0] RDATA;
  wire SCL_O, SCL_OE, SDA_O, SDA_OE, m_scl, m_sda;
  wire scl = (SCL_OE ? SCL_O : 1'h1) & ~m_scl;
  wire sda = (SDA_OE ? SDA_O : 1'h1) & ~m_sda;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] own, d, t, r;
  logic a;
  i2c_slave_stretch dut (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_I(scl), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
    .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
  ext_master_model m (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
  initial begin
    forever #5 CLK = ~CLK;
  end
  task wrap_up;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      wrap_up;
    end
  end
  task wr(input logic [7:0] ad, input logic [7:0] v);
    begin
      @(posedge CLK);
      ADDR <= ad;
      WDATA <= v;
      WR <= 1'h1;
      @(posedge CLK);
      WR <= 1'h0;
    end
  endtask
  task rchk(input logic [7:0] ad, input logic [7:0] mk, input logic [7:0] e);
    begin
      @(posedge CLK);
      ADDR <= ad;
      RD <= 1'h1;
      @(posedge CLK);
      RD <= 1'h0;
      #1;
      `CHK("register", e, RDATA & mk)
    end
  endtask
  task settle(input logic e);
    begin
      repeat (6) @(posedge CLK);
      `CHK("scl_oe", e, SCL_OE)
    end
  endtask
  task stop_run;
    begin
      wr(8'h05, 8'h01);
      repeat (300) @(posedge CLK);
    end
  endtask
  initial begin
    d = $urandom(32'he3cad22c);
    repeat (8) @(posedge CLK);
    SYS_RST <= 1'h0;
    rchk(8'h00, 8'hff, 8'h02);
    rchk(8'h01, 8'hff, 8'h00);
    rchk(8'h04, 8'hff, 8'h10);
    wr(8'h3c, 8'h55);
    rchk(8'h3c, 8'hff, 8'h00);
    wr(8'h00, 8'h00);
    settle(1'h1);
    wr(8'h00, 8'h03);
    rchk(8'h00, 8'h01, 8'h01);
    settle(1'h0);
    own = 8'h08 + ($urandom % 8'h60);
    wr(8'h03, own);
    m.start_cond;
    m.byte_io({own[6:0], 1'h0}, 1'h1, r, a);
    `CHK("ack", 1'h0, a)
    settle(1'h0);
    rchk(8'h02, 8'hff, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      m.byte_io(d, 1'h1, r, a);
      settle(1'h1);
      rchk(8'h00, 8'h02, 8'h00);
      rchk(8'h02, 8'hff, d);
      rchk(8'h01, 8'h01, 8'h00);
      wr(8'h00, 8'h03);
    end
    m.stop_cond;
    wr(8'h00, 8'h02);
    m.start_cond;
    m.byte_io({own[6:0], 1'h0}, 1'h1, r, a);
    rchk(8'h01, 8'h01, 8'h00);
    d = $urandom;
    m.byte_io(d, 1'h1, r, a);
    settle(1'h0);
    rchk(8'h00, 8'h02, 8'h02);
    rchk(8'h02, 8'hff, d);
    m.stop_cond;
    m.start_cond;
    m.byte_io({own[6:0], 1'h1}, 1'h1, r, a);
    settle(1'h1);
    rchk(8'h00, 8'h02, 8'h00);
    t = $urandom;
    d = ~t;
    wr(8'h02, t);
    wr(8'h00, 8'h02);
    // Second load lands after bit eight, before the ninth fall
    fork
      m.byte_io(8'hff, 1'h0, r, a);
      begin
        repeat (133) @(posedge CLK);
        wr(8'h02, d);
      end
    join
    `CHK("tx byte", t, r)
    settle(1'h0);
    m.byte_io(8'hff, 1'h1, r, a);
    `CHK("tx byte", d, r)
    wr(8'h00, 8'h02);
    m.stop_cond;
    t = 8'h08 + ($urandom % 8'h10);
    wr(8'h04, t);
    rchk(8'h04, 8'h7f, t);
    stop_run;
    rchk(8'h01, 8'h18, 8'h00);
    `CHK("sda_oe", 1'h0, SDA_OE)
    m.jam(1'h1);
    stop_run;
    rchk(8'h01, 8'h18, 8'h08);
    `CHK("sda_oe", 1'h0, SDA_OE)
    `CHK("scl_oe", 1'h0, SCL_OE)
    m.jam(1'h0);
    wr(8'h05, 8'h02);
    rchk(8'h01, 8'h08, 8'h00);
    // Clock pulled low by another master while the stop counts
    wr(8'h05, 8'h01);
    repeat (6) @(posedge CLK);
    m.jam_clk(1'h1);
    repeat (20) @(posedge CLK);
    m.jam_clk(1'h0);
    repeat (6) @(posedge CLK);
    rchk(8'h01, 8'h18, 8'h08);
    `CHK("sda_oe", 1'h0, SDA_OE)
    wrap_up;
  end
endmodule
